// [rtl/irq_ctrl_pkg.sv]
// Purpose: Shared constants and types for the vectored interrupt controller
// Assumes: Single 50 MHz core clock, synchronous active-low reset
// Notes: Vector index 0..9 maps to addresses 00003H + 8*index
package irq_ctrl_pkg;
    localparam int NUM_SRC = 27;
    localparam int NUM_VEC = 10;
    localparam int VEC_W = 4;
    localparam int SRC_W = 5;
    localparam logic [16:0] VEC_BASE = 17'h00003;
    localparam logic [16:0] VEC_STEP = 17'h00008;

    // Priority levels, ordered top above high above low
    typedef enum logic [1:0] {
        LVL_NONE = 2'b00,
        LVL_LOW = 2'b01,
        LVL_HIGH = 2'b10,
        LVL_TOP = 2'b11
    } level_t;

    // Trigger modes of an external pin detector
    typedef enum logic [2:0] {
        TRIG_RISE = 3'b000,
        TRIG_FALL = 3'b001,
        TRIG_BOTH = 3'b010,
        TRIG_HIGH = 3'b011,
        TRIG_LOW = 3'b100
    } trig_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_PAUSE = 2'b01,
        PWR_DEEP = 2'b10,
        PWR_XTAL = 2'b11
    } pwr_t;

    // Source bit positions
    localparam int S_EXT_A = 0;
    localparam int S_EXT_B = 1;
    localparam int S_EXT_C = 2;
    localparam int S_TMR0_LO = 3;
    localparam int S_EXT_E = 4;
    localparam int S_EXT_D = 5;
    localparam int S_EXT_F = 6;
    localparam int S_BT0 = 7;
    localparam int S_BT1 = 8;
    localparam int S_TMR0_HI = 9;
    localparam int S_EXT_G = 10;
    localparam int S_TMR1_LO = 11;
    localparam int S_TMR1_HI = 12;
    localparam int S_EXT_H = 13;
    localparam int S_SSER_A = 14;
    localparam int S_UART1_RX = 15;
    localparam int S_UART2_RX = 16;
    localparam int S_SSER_TX = 17;
    localparam int S_UART1_TX = 18;
    localparam int S_UART2_TX = 19;
    localparam int S_ADC = 20;
    localparam int S_TMR6 = 21;
    localparam int S_TMR7 = 22;
    localparam int S_PORT0 = 23;
    localparam int S_TMR4 = 24;
    localparam int S_TMR5 = 25;
    localparam int S_PWM12 = 26;

    // Source to vector map, one 27-bit mask per vector
    localparam logic [NUM_SRC-1:0] VEC_SRC_MAP [NUM_VEC] = '{
        27'h0000001, 27'h0000002, 27'h000001c, 27'h00001e0, 27'h0000600,
        27'h0003800, 27'h001c000, 27'h00e0000, 27'h0700000, 27'h7800000
    };

    // Vectors 0 and 1 choose top or low; the rest choose high or low
    localparam int NUM_TOPCAP = 2;

    // Per-pin trigger capability: bit order rise, fall, both, high, low
    localparam logic [4:0] CAP_AB = 5'h1b;
    localparam logic [4:0] CAP_EDGE3 = 5'h07;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vec;
        logic [16:0] addr;
        level_t level;
    } grant_t;
endpackage : irq_ctrl_pkg

// [rtl/irq_ctrl.sv]
// Purpose: Multilevel vectored interrupt controller with pin detectors and standby wake-up
// Assumes: Peripheral requests are one-cycle pulses on i_core_clk; pins are asynchronous
// Notes: The core takes a grant with i_ack and signals return with i_reti
//
// Notes on behaviour
// - Three levels exist, top above high above low, used for both arbitration and masking.
// - During service at a level, only requests of a strictly higher level are accepted.
// - Among pending vectors, the one with the highest assigned level is granted.
// - Among equal levels, the smallest vector address wins.
// - Twenty-seven sources are gathered onto ten vectors, several sharing a vector.
// - Vectors at 00003H and 0000BH serve pins a and b and take top or low level.
// - Vectors 00013H to 0002BH serve pins c to h and the timer halves, high or low level.
// - Vectors 00033H to 0004BH serve serial, converter, timer, port and pulse sources, high or low.
// - Pause mode stops the core, keeps peripherals running, and ends on reset or any request.
// - Deep stop ends on reset pin low, pins a b c e f at their level, or a port 0 source.
// - Crystal-keep stop ends on the deep stop events or on a base timer source.
// - The pin e detector supports rising, falling and both edges, never levels.
// - Pin a and b detectors support rising, falling, high and low, never both edges.
// - Pin c, d and f detectors support rising, falling and both edges, never levels.
`timescale 1ns/100ps
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int NEST_DEPTH = 3
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_ext_pin,
    input wire logic [NUM_SRC-1:0] i_periph_req,
    input wire logic [NUM_SRC-1:0] i_src_clear,
    input wire logic [NUM_SRC-1:0] i_src_enable,
    input wire trig_t [7:0] i_trig_mode,
    input wire logic [NUM_VEC-1:0] i_vec_upper,
    input wire logic i_ack,
    input wire logic i_reti,
    input wire pwr_t i_pwr_req,
    input wire logic i_reset_pin_n,
    output logic o_irq,
    output grant_t o_grant,
    output logic [NUM_SRC-1:0] o_pending,
    output level_t o_active_level,
    output pwr_t o_pwr_state,
    output logic o_core_halt,
    output logic o_wake
);
    function automatic logic [4:0] pin_cap(input int idx);
        if (idx <= 1) begin
            pin_cap = CAP_AB;
        end else begin
            pin_cap = CAP_EDGE3;
        end
    endfunction : pin_cap

    function automatic level_t vec_level(input int v, input logic upper);
        if (!upper) begin
            vec_level = LVL_LOW;
        end else if (v < NUM_TOPCAP) begin
            vec_level = LVL_TOP;
        end else begin
            vec_level = LVL_HIGH;
        end
    endfunction : vec_level

    // Vector slots are eight bytes apart from the first one
    function automatic logic [16:0] vec_addr(input logic [VEC_W-1:0] v);
        vec_addr = VEC_BASE + 17'(v) * VEC_STEP;
    endfunction : vec_addr

    // Two flops per pin keep metastability away from the detectors
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;
    logic rst_pin_s1;
    logic rst_pin_s2;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            pin_prev <= 8'h00;
        end else begin
            pin_s1 <= i_ext_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // Reset pin idles high so no false wake follows reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rst_pin_s1 <= 1'b1;
            rst_pin_s2 <= 1'b1;
        end else begin
            rst_pin_s1 <= i_reset_pin_n;
            rst_pin_s2 <= rst_pin_s1;
        end
    end

    wire [7:0] pin_rise;
    wire [7:0] pin_fall;
    assign pin_rise = pin_s2 & ~pin_prev;
    assign pin_fall = ~pin_s2 & pin_prev;

    // Pin detectors: a mode the pin does not support detects nothing
    logic [7:0] pin_event;
    logic [7:0] pin_level_met;
    always_comb begin
        logic [4:0] cap;
        cap = 5'h00;
        for (int i = 0; i < 8; i++) begin
            cap = pin_cap(i);
            pin_event[i] = 1'b0;
            pin_level_met[i] = 1'b0;
            case (i_trig_mode[i])
                TRIG_RISE: begin
                    pin_event[i] = cap[0] & pin_rise[i];
                    pin_level_met[i] = cap[0] & pin_s2[i];
                end
                TRIG_FALL: begin
                    pin_event[i] = cap[1] & pin_fall[i];
                    pin_level_met[i] = cap[1] & ~pin_s2[i];
                end
                TRIG_BOTH: begin
                    pin_event[i] = cap[2] & (pin_s2[i] ^ pin_prev[i]);
                    pin_level_met[i] = pin_event[i];
                end
                TRIG_HIGH: begin
                    pin_event[i] = cap[3] & pin_s2[i];
                    pin_level_met[i] = pin_event[i];
                end
                TRIG_LOW: begin
                    pin_event[i] = cap[4] & ~pin_s2[i];
                    pin_level_met[i] = pin_event[i];
                end
                default: begin
                    pin_event[i] = 1'b0;
                    pin_level_met[i] = 1'b0;
                end
            endcase
        end
    end

    // Merge pin detectors into the source vector
    wire [NUM_SRC-1:0] raw_req;
    assign raw_req = i_periph_req
        | (NUM_SRC'(pin_event[0]) << S_EXT_A)
        | (NUM_SRC'(pin_event[1]) << S_EXT_B)
        | (NUM_SRC'(pin_event[2]) << S_EXT_C)
        | (NUM_SRC'(pin_event[3]) << S_EXT_D)
        | (NUM_SRC'(pin_event[4]) << S_EXT_E)
        | (NUM_SRC'(pin_event[5]) << S_EXT_F)
        | (NUM_SRC'(pin_event[6]) << S_EXT_G)
        | (NUM_SRC'(pin_event[7]) << S_EXT_H);

    // Pending flags and per-vector requests
    // Disabled sources still collect so that enabling later loses nothing
    logic [NUM_SRC-1:0] pending;
    logic [NUM_VEC-1:0] vec_pend;
    level_t vec_lvl [NUM_VEC];
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            vec_pend[v] = |(pending & i_src_enable & VEC_SRC_MAP[v]);
            vec_lvl[v] = vec_level(v, i_vec_upper[v]);
        end
    end

    // Arbiter: highest level, then lowest vector index
    logic [1:0] nest_cnt;
    level_t nest_stack [NEST_DEPTH];
    level_t active_level;
    level_t best_lvl;
    logic [VEC_W-1:0] best_vec;
    logic best_found;
    always_comb begin
        best_lvl = LVL_NONE;
        best_vec = '0;
        best_found = 1'b0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (vec_pend[v] && vec_lvl[v] >= best_lvl) begin
                best_lvl = vec_lvl[v];
                best_vec = VEC_W'(v);
                best_found = 1'b1;
            end
        end
    end

    wire accept;
    assign accept = best_found && (best_lvl > active_level);

    // Only the lowest-index pending source of the granted vector is retired on ack
    logic [NUM_SRC-1:0] grant_src;
    always_comb begin
        logic [NUM_SRC-1:0] cand;
        logic taken;
        cand = pending & i_src_enable & VEC_SRC_MAP[o_grant.vec];
        taken = 1'b0;
        grant_src = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (cand[s] && !taken) begin
                grant_src[s] = 1'b1;
                taken = 1'b1;
            end
        end
    end

    wire take;
    assign take = i_ack && o_grant.valid;

    wire [NUM_SRC-1:0] next_pending;
    // Set wins over clear so a same-cycle event is kept
    assign next_pending = raw_req | (pending & ~i_src_clear & ~(take ? grant_src : '0));

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // Next grant, cleared once the core has taken it
    grant_t next_grant;
    always_comb begin
        next_grant = '0;
        if (!take) begin
            next_grant.valid = accept;
            next_grant.vec = best_vec;
            next_grant.addr = vec_addr(best_vec);
            next_grant.level = accept ? best_lvl : LVL_NONE;
        end
    end

    // Grant register presented to the core
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_grant <= '0;
        end else begin
            o_grant <= next_grant;
        end
    end

    // Push only while a slot is free; three levels never need more than three
    wire nest_push;
    wire nest_pop;
    assign nest_push = take && (o_grant.level > active_level) && (nest_cnt < 2'(NEST_DEPTH));
    assign nest_pop = i_reti && (nest_cnt != 2'd0);

    // Level nesting stack
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nest_cnt <= 2'd0;
            active_level <= LVL_NONE;
            for (int i = 0; i < NEST_DEPTH; i++) begin
                nest_stack[i] <= LVL_NONE;
            end
        end else if (nest_push) begin
            nest_stack[nest_cnt] <= active_level;
            nest_cnt <= nest_cnt + 2'd1;
            active_level <= o_grant.level;
        end else if (nest_pop) begin
            nest_cnt <= nest_cnt - 2'd1;
            active_level <= nest_stack[nest_cnt - 2'd1];
        end
    end

    // Standby control
    pwr_t pwr_state;
    pwr_t next_pwr;
    wire any_req;
    wire stop_wake;
    wire xtal_wake;
    assign any_req = |next_pending;
    wire pin_wake;
    wire port_wake;
    wire bt_wake;
    wire next_wake;
    assign pin_wake = pin_level_met[0] || pin_level_met[1] || pin_level_met[2] || pin_level_met[4]
        || pin_level_met[5];
    assign port_wake = raw_req[S_PORT0];
    assign bt_wake = raw_req[S_BT0] || raw_req[S_BT1];
    assign stop_wake = !rst_pin_s2 || pin_wake || port_wake;
    assign xtal_wake = stop_wake || bt_wake;

    always_comb begin
        next_pwr = pwr_state;
        case (pwr_state)
            PWR_RUN: next_pwr = i_pwr_req;
            PWR_PAUSE: next_pwr = any_req ? PWR_RUN : PWR_PAUSE;
            PWR_DEEP: next_pwr = stop_wake ? PWR_RUN : PWR_DEEP;
            PWR_XTAL: next_pwr = xtal_wake ? PWR_RUN : PWR_XTAL;
            default: next_pwr = PWR_RUN;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pwr_state <= PWR_RUN;
        end else begin
            pwr_state <= next_pwr;
        end
    end

    // Wake pulse marks the single cycle in which standby ends
    assign next_wake = (pwr_state != PWR_RUN) && (next_pwr == PWR_RUN);
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= next_wake;
        end
    end

    assign o_irq = o_grant.valid;
    assign o_pending = pending;
    assign o_active_level = active_level;
    assign o_pwr_state = pwr_state;
    // Peripherals keep running in pause; only the core is held
    assign o_core_halt = (pwr_state != PWR_RUN);
endmodule : irq_ctrl

// [sim/irq_ctrl_monitor.sv]
// Purpose: Port-level checks for the vectored interrupt controller
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Bound to the controller from the bench top file
`timescale 1ns/100ps
module irq_ctrl_monitor
    import irq_ctrl_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_SRC-1:0] i_periph_req,
    input wire logic [NUM_SRC-1:0] i_src_clear,
    input wire logic i_ack,
    input wire logic o_irq,
    input wire grant_t o_grant,
    input wire logic [NUM_SRC-1:0] o_pending,
    input wire level_t o_active_level,
    input wire pwr_t o_pwr_state,
    input wire logic o_core_halt,
    input wire logic o_wake
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_take;
        o_irq && i_ack;
    endsequence
    sequence s_retired;
        !o_irq && o_active_level == $past(o_grant.level);
    endsequence
    addr_from_vec_a: assert property (
        o_irq |-> o_grant.addr == VEC_BASE + VEC_STEP * o_grant.vec) else $error("grant address wrong");
    above_active_a: assert property (
        o_irq |-> o_grant.level > o_active_level) else $error("grant not above active level");
    level_class_a: assert property (
        o_irq |-> (o_grant.vec < 2) == (o_grant.level inside {LVL_TOP, LVL_LOW}) || o_grant.level == LVL_LOW)
        else $error("grant level class wrong");
    take_sets_level_a: assert property (s_take |=> s_retired) else $error("taken level not active");
    pend_set_a: assert property (
        !i_ack && i_periph_req != '0 |=> (o_pending & $past(i_periph_req)) == $past(i_periph_req))
        else $error("request not pending");
    pend_hold_a: assert property (
        !i_ack && i_src_clear == '0 |=> ($past(o_pending) & ~o_pending) == '0) else $error("pending lost");
    halt_state_a: assert property (o_core_halt == (o_pwr_state != PWR_RUN)) else $error("halt mismatch");
    pause_wake_a: assert property (
        o_pwr_state == PWR_PAUSE && o_pending != '0 |-> ##[0:3] o_pwr_state == PWR_RUN) else $error("pause stuck");
    wake_pulse_a: assert property (o_wake |-> o_pwr_state == PWR_RUN ##1 !o_wake) else $error("wake pulse bad");
endmodule : irq_ctrl_monitor

// [sim/irq_core_model.sv]
// Purpose: Core-side model that takes a grant when told to
// Assumes: One take command per grant
// Notes: Delay input lets the bench answer promptly or slowly
`timescale 1ns/100ps
module irq_core_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_irq,
    input wire logic i_take,
    input wire logic [3:0] i_dly,
    output logic o_ack = 1'b0
);
    logic want = 1'b0;
    logic [3:0] cnt = 4'h0;
    // Ack only while a grant stands, never twice for one take
    always @(posedge i_core_clk) begin
        o_ack <= 1'b0;
        if (!i_rst_n) begin
            want <= 1'b0;
        end else if (i_take) begin
            want <= 1'b1;
            cnt <= i_dly;
        end else if (want && i_irq && !o_ack) begin
            if (cnt == 4'h0) begin
                o_ack <= 1'b1;
                want <= 1'b0;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : irq_core_model

// [sim/irq_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the vectored interrupt controller
// Assumes: Core model acks on command; bench drives returns
// Notes: Inputs change at rising edges, i_vec_upper and the i_src_enable clear in t_pins at falling edges; checks at falling edges
`timescale 1ns/100ps
module irq_ctrl_tb_top
    import irq_ctrl_pkg::*;
;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_ack, i_reti = 1'b0, i_reset_pin_n = 1'b1, take = 1'b0;
    logic o_irq, o_core_halt, o_wake;
    logic [3:0] ack_dly = 4'h0;
    logic [7:0] i_ext_pin = 8'h00;
    logic [NUM_SRC-1:0] i_periph_req = '0, i_src_clear = '0, i_src_enable = '1, o_pending;
    trig_t [7:0] i_trig_mode = {8{TRIG_RISE}};
    logic [NUM_VEC-1:0] i_vec_upper = '1;
    pwr_t i_pwr_req = PWR_RUN, o_pwr_state;
    grant_t o_grant;
    level_t o_active_level;
    int failures = 0, tests_run = 0;
    always #10 i_core_clk = ~i_core_clk;
    irq_ctrl irq_ctrl_inst (.i_core_clk, .i_rst_n, .i_ext_pin, .i_periph_req, .i_src_clear, .i_src_enable,
        .i_trig_mode, .i_vec_upper, .i_ack, .i_reti, .i_pwr_req, .i_reset_pin_n, .o_irq, .o_grant,
        .o_pending, .o_active_level, .o_pwr_state, .o_core_halt, .o_wake);
    irq_core_model irq_core_model_inst (.i_core_clk, .i_rst_n, .i_irq(o_irq), .i_take(take),
        .i_dly(ack_dly), .o_ack(i_ack));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : cyc
    task automatic pulse(input logic [NUM_SRC-1:0] m);
        @(posedge i_core_clk);
        i_periph_req <= m;
        @(posedge i_core_clk);
        i_periph_req <= '0;
    endtask : pulse
    // Clear is held over several edges so a late detector event is swept too
    task automatic clr();
        @(posedge i_core_clk);
        i_src_clear <= '1;
        repeat (3) @(posedge i_core_clk);
        i_src_clear <= '0;
    endtask : clr
    task automatic serve(input int v, input level_t lvl);
        int k;
        for (k = 0; k < 20 && o_irq !== 1'b1; k++) cyc(1);
        chk("vector", o_grant.vec, v);
        chk("address", o_grant.addr, VEC_BASE + VEC_STEP * v);
        chk("level", o_grant.level, lvl);
        @(posedge i_core_clk);
        take <= 1'b1;
        @(posedge i_core_clk);
        take <= 1'b0;
        for (k = 0; k < 20 && o_active_level !== lvl; k++) cyc(1);
        chk("active", o_active_level, lvl);
    endtask : serve
    task automatic ret(input level_t lvl);
        @(posedge i_core_clk);
        i_reti <= 1'b1;
        @(posedge i_core_clk);
        i_reti <= 1'b0;
        cyc(1);
        chk("restored", o_active_level, lvl);
    endtask : ret
    task automatic t_vectors();
        int vec_of [NUM_SRC] = '{0, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 5, 6, 6, 6, 7, 7, 7, 8, 8, 8, 9, 9, 9, 9};
        for (int s = 0; s < NUM_SRC; s++) begin
            ack_dly <= 4'(s % 4);
            pulse(27'(1) << s);
            serve(vec_of[s], vec_of[s] < 2 ? LVL_TOP : LVL_HIGH);
            ret(LVL_NONE);
        end
    endtask : t_vectors
    task automatic t_priority();
        i_vec_upper <= 10'h208;
        pulse(27'h0800221);
        serve(3, LVL_HIGH);
        cyc(5);
        chk("refused", o_irq, 1'b0);
        i_vec_upper <= 10'h20a;
        pulse(27'h0000002);
        serve(1, LVL_TOP);
        ret(LVL_HIGH);
        ret(LVL_NONE);
        serve(9, LVL_HIGH);
        ret(LVL_NONE);
        serve(0, LVL_LOW);
        ret(LVL_NONE);
        serve(4, LVL_LOW);
        ret(LVL_NONE);
        i_vec_upper <= '1;
    endtask : t_priority
    task automatic t_shared();
        pulse(27'h0002800);
        serve(5, LVL_HIGH);
        chk("kept", o_pending[13:11], 3'h4);
        ret(LVL_NONE);
        serve(5, LVL_HIGH);
        ret(LVL_NONE);
        chk("drained", o_pending, 0);
    endtask : t_shared
    // Only what follows the clear counts: the falling edge, a low level, or a high level still in the synchronizer, so rise-only modes stay quiet
    task automatic t_pins();
        int pn [10] = '{0, 0, 1, 1, 2, 2, 3, 4, 4, 5};
        trig_t pm [10] = '{TRIG_BOTH, TRIG_LOW, TRIG_FALL, TRIG_HIGH, TRIG_BOTH, TRIG_HIGH, TRIG_LOW, TRIG_BOTH,
            TRIG_LOW, TRIG_RISE};
        logic pe [10] = '{0, 1, 1, 1, 1, 0, 0, 1, 0, 0};
        int psrc [8] = '{0, 1, 2, 5, 4, 6, 10, 13};
        i_src_enable <= '0;
        foreach (pn[k]) begin
            @(posedge i_core_clk);
            i_ext_pin[pn[k]] <= 1'b1;
            i_trig_mode[pn[k]] <= pm[k];
            cyc(5);
            clr();
            @(posedge i_core_clk);
            i_ext_pin[pn[k]] <= 1'b0;
            cyc(6);
            chk("pin", o_pending[psrc[pn[k]]], pe[k]);
            @(posedge i_core_clk);
            i_trig_mode[pn[k]] <= TRIG_RISE;
            clr();
        end
    endtask : t_pins
    task automatic t_power();
        pwr_t md [5] = '{PWR_PAUSE, PWR_DEEP, PWR_DEEP, PWR_DEEP, PWR_XTAL};
        int src [5] = '{24, 24, 7, 23, 7};
        logic wk [5] = '{1, 0, 0, 1, 1};
        foreach (md[k]) begin
            @(posedge i_core_clk);
            i_pwr_req <= md[k];
            @(posedge i_core_clk);
            i_pwr_req <= PWR_RUN;
            cyc(2);
            chk("halt", o_core_halt, 1'b1);
            pulse(27'(1) << src[k]);
            cyc(4);
            chk("wake", o_core_halt, !wk[k]);
            @(posedge i_core_clk);
            i_reset_pin_n <= 1'b0;
            @(posedge i_core_clk);
            i_reset_pin_n <= 1'b1;
            cyc(6);
            chk("run", o_pwr_state, PWR_RUN);
            clr();
        end
        i_src_enable <= '1;
    endtask : t_power
    task automatic t_reset();
        chk("reset", {o_pending, o_irq, o_wake}, 0);
        chk("reset", {o_active_level, o_pwr_state, o_core_halt}, 0);
    endtask : t_reset
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        cyc(1);
        t_reset();
        t_vectors();
        t_priority();
        t_shared();
        t_pins();
        t_power();
        wrap_up();
    end
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule : irq_ctrl_tb_top
bind irq_ctrl irq_ctrl_monitor irq_ctrl_monitor_inst (.i_core_clk, .i_rst_n, .i_periph_req, .i_src_clear, .i_ack,
    .o_irq, .o_grant, .o_pending, .o_active_level, .o_pwr_state, .o_core_halt, .o_wake);
